//--- hw/rail2_phase_shed_loop_ctrl.sv
// Rail 2 phase-shedding, frequency and balance loop control with its command registers
// Notes on behaviour
// R1 - AVS current report scaled by 11-bit gain
// R2 - Hysteresis equals phases times increment plus base
// R3 - Shed level equals phases times increment plus base
// R4 - Overcurrent exit waits count times 100 ns
// R5 - Overcurrent forces full phase when enabled
// R6 - Overcurrent exits in single phase when enabled
// R7 - Undervoltage forces full phase when enabled
// R8 - Frequency rise exits shedding when enabled
// R9 - Frequency limit 40 to 180 percent
// R10 - Enter after current below level N reports
// R11 - First phase off time can end shedding
// R12 - Phase interval time can end shedding
// R13 - Consecutive condition count reaching threshold exits
// R14 - Hold full phase after frequency exit
// R15 - Drop one phase per 2.5 us step
// R16 - Frequency loop runs when enabled
// R17 - Frequency loop held on enabled events
// R18 - Frequency hold lasts count times 100 us
// R19 - Balance loop enable and hold events
// R20 - Balance hold lasts count times 100 us
// R21 - VID step decoded per sense gain
// R22 - Sense gain and amplifier input select
// R23 - Drop mode: one by one or direct
// R24 - AVS resolution 160 or 320 mA
// R25 - Exit beats entry in same cycle
`timescale 1ns/1ps
module rail2_phase_shed_loop_ctrl #(
   parameter int HOLD_STEP_CYC = shed_pkg::HOLD_STEP_CYC
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              cmd_wr,
   input  wire logic              cmd_rd,
   input  wire logic [7:0]        cmd_code,
   input  wire logic [15:0]       cmd_wdata,
   output logic [15:0]            cmd_rdata,
   output logic                   cmd_rvalid,
   output logic                   cmd_nack,
   input  wire logic [3:0]        phase_num_cfg,
   input  wire logic              phase_drop_mode,
   input  wire logic              avs_res_sel,
   input  wire logic [7:0]        iout_a,
   input  wire logic              iout_strobe,
   input  wire shed_pkg::shed_evt_s evt,
   output logic                   shed_active,
   output logic [3:0]             phase_target,
   output logic [7:0]             freq_limit_pct,
   output logic                   freq_loop_run,
   output logic                   balance_loop_run,
   output logic [15:0]            avs_current_report,
   output shed_pkg::vout_cfg_s    vout_cfg
);
   localparam int TW = 20;

   logic [15:0]           thr_r;
   logic [15:0]           tim_r;
   logic [15:0]           det_r;
   logic [15:0]           loop_r;
   logic [15:0]           out_r;
   shed_pkg::shed_state_e state_r;
   logic [3:0]            phase_target_r;
   logic [3:0]            target_prev_r;
   logic [4:0]            below_cnt_r;
   logic [2:0]            off_cnt_r;
   logic [2:0]            ivl_cnt_r;
   logic [7:0]            freq_limit_pct_r;
   logic                  freq_loop_run_r;
   logic                  balance_loop_run_r;
   logic [15:0]           avs_r;
   shed_pkg::vout_cfg_s   vout_cfg_r;
   logic [15:0]           cmd_rdata_r;
   logic                  cmd_rvalid_r;
   logic                  cmd_nack_r;
   logic [9:0]            level_now;
   logic [9:0]            hyst_now;
   logic [3:0]            fit_now;
   logic                  in_shed;
   logic                  enter_ok;
   logic                  exit_ocp;
   logic                  exit_uv;
   logic                  exit_fs;
   logic                  exit_cur;
   logic                  exit_any;
   logic                  off_hit;
   logic                  ivl_hit;
   logic                  phase_chg;
   logic                  freq_evt;
   logic                  bal_evt;
   logic                  ocp_busy;
   logic                  ocp_done;
   logic                  rt_busy;
   logic                  drop_busy;
   logic                  drop_done;
   logic                  drop_req;
   logic                  freq_busy;
   logic                  bal_busy;
   logic [18:0]           avs_prod;

   function automatic logic [9:0] shed_level(input logic [3:0] n, input logic [5:0] inc,
                                             input logic [3:0] base);
      return 10'(n) * 10'(inc) + 10'(base);
   endfunction : shed_level

   // Fewest phases whose level still exceeds the load
   function automatic logic [3:0] fit_phases(input logic [7:0] amps, input logic [5:0] inc,
                                             input logic [3:0] base, input logic [3:0] maxp);
      logic [3:0] n;
      int         k;
      n = maxp;
      for (k = 15; k >= 1; k--)
      begin
         if (4'(k) <= maxp && {2'b00, amps} < shed_level(4'(k), inc, base))
            n = 4'(k);
      end
      return n;
   endfunction : fit_phases

   function automatic logic is_mapped(input logic [7:0] code);
      return code == shed_pkg::OFS_SHED_THRESHOLD || code == shed_pkg::OFS_SHED_TIMING_EXIT ||
             code == shed_pkg::OFS_SHED_EXIT_DETECT || code == shed_pkg::OFS_FREQ_BALANCE ||
             code == shed_pkg::OFS_OUTPUT_LOOP;
   endfunction : is_mapped

   // Command writes
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         thr_r  <= shed_pkg::RST_REG;
         tim_r  <= shed_pkg::RST_REG;
         det_r  <= shed_pkg::RST_REG;
         loop_r <= shed_pkg::RST_REG;
         out_r  <= shed_pkg::RST_REG;
      end
      else if (cmd_wr)
      begin
         case (cmd_code)
            shed_pkg::OFS_SHED_THRESHOLD:   thr_r  <= cmd_wdata;
            shed_pkg::OFS_SHED_TIMING_EXIT: tim_r  <= cmd_wdata;
            shed_pkg::OFS_SHED_EXIT_DETECT: det_r  <= cmd_wdata;
            shed_pkg::OFS_FREQ_BALANCE:     loop_r <= cmd_wdata;
            shed_pkg::OFS_OUTPUT_LOOP:      out_r  <= cmd_wdata & shed_pkg::OUTPUT_LOOP_WMASK;
            default:                        out_r  <= out_r;
         endcase
      end
   end

   // Command reads, one cycle after the request
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cmd_rdata_r  <= 16'h0000;
         cmd_rvalid_r <= 1'b0;
         cmd_nack_r   <= 1'b0;
      end
      else
      begin
         cmd_rvalid_r <= cmd_rd;
         cmd_nack_r   <= (cmd_rd || cmd_wr) && !is_mapped(cmd_code);
         if (cmd_rd)
         begin
            case (cmd_code)
               shed_pkg::OFS_SHED_THRESHOLD:   cmd_rdata_r <= thr_r;
               shed_pkg::OFS_SHED_TIMING_EXIT: cmd_rdata_r <= tim_r;
               shed_pkg::OFS_SHED_EXIT_DETECT: cmd_rdata_r <= det_r;
               shed_pkg::OFS_FREQ_BALANCE:     cmd_rdata_r <= loop_r;
               shed_pkg::OFS_OUTPUT_LOOP:      cmd_rdata_r <= out_r;
               default:                        cmd_rdata_r <= 16'h0000;
            endcase
         end
      end
   end

   assign in_shed   = (state_r == shed_pkg::ST_SHED);
   assign level_now = shed_level(phase_target_r, thr_r[shed_pkg::LEVEL_INC_LSB +: 6],
                                 thr_r[shed_pkg::LEVEL_BASE_LSB +: 4]); // R3
   assign hyst_now  = shed_level(phase_target_r, {4'h0, thr_r[shed_pkg::HYST_INC_LSB +: 2]},
                                 thr_r[shed_pkg::HYST_BASE_LSB +: 4]); // R2
   assign fit_now   = fit_phases(iout_a, thr_r[shed_pkg::LEVEL_INC_LSB +: 6],
                                 thr_r[shed_pkg::LEVEL_BASE_LSB +: 4], phase_num_cfg);

   // Entry qualification over current reports
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         below_cnt_r <= 5'h00;
      else if (in_shed)
         below_cnt_r <= 5'h00;
      else if (iout_strobe)
      begin
         if ({2'b00, iout_a} < level_now) // R10
            below_cnt_r <= (below_cnt_r == 5'h1f) ? below_cnt_r : below_cnt_r + 5'h01;
         else
            below_cnt_r <= 5'h00;
      end
   end

   assign enter_ok = !rt_busy && phase_num_cfg > 4'h1 && below_cnt_r != 5'h00 &&
                     below_cnt_r >= tim_r[shed_pkg::ENTRY_DELAY_LSB +: 5]; // R10 R14

   // Consecutive off-time and interval conditions
   always_ff @(posedge clk)
   begin
      if (!rst_b || !in_shed)
         off_cnt_r <= 3'h0;
      else if (evt.pwm1_cycle)
         off_cnt_r <= !evt.offtime_met ? 3'h0 :
                      (off_cnt_r == 3'h7) ? off_cnt_r : off_cnt_r + 3'h1; // R11 R13
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || !in_shed)
         ivl_cnt_r <= 3'h0;
      else if (evt.pwm_np_cycle)
         ivl_cnt_r <= !evt.interval_met ? 3'h0 :
                      (ivl_cnt_r == 3'h7) ? ivl_cnt_r : ivl_cnt_r + 3'h1; // R12 R13
   end

   assign off_hit = det_r[shed_pkg::OFFTIME_EN_BIT] &&
                    det_r[shed_pkg::OFFTIME_CNT_LSB +: 3] != 3'h0 &&
                    off_cnt_r >= det_r[shed_pkg::OFFTIME_CNT_LSB +: 3]; // R11 R13
   assign ivl_hit = det_r[shed_pkg::INTERVAL_EN_BIT] &&
                    det_r[shed_pkg::INTERVAL_CNT_LSB +: 3] != 3'h0 &&
                    ivl_cnt_r >= det_r[shed_pkg::INTERVAL_CNT_LSB +: 3]; // R12 R13

   // Exit causes
   assign exit_ocp = ocp_done && (tim_r[shed_pkg::OCP_FULL_BIT] ||
                     (tim_r[shed_pkg::OCP_SINGLE_BIT] && evt.single_phase)); // R5 R6
   assign exit_uv  = tim_r[shed_pkg::UV_EXIT_BIT] && evt.uv_low; // R7
   assign exit_fs  = (tim_r[shed_pkg::FREQ_RISE_BIT] && evt.freq_rise) || off_hit || ivl_hit; // R8
   assign exit_cur = iout_strobe && {2'b00, iout_a} >= level_now + hyst_now; // R2
   assign exit_any = exit_ocp || exit_uv || exit_fs || exit_cur;

   hold_timer #(.W(TW)) u_ocp_timer (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (evt.per_phase_overcurrent && !ocp_busy),
      .cycles (TW'(tim_r[shed_pkg::OCP_DELAY_LSB +: 4]) * TW'(shed_pkg::OCP_STEP_CYC)), // R4
      .busy   (ocp_busy),
      .done   (ocp_done)
   );

   hold_timer #(.W(TW)) u_runtime_timer (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (in_shed && exit_fs), // R14
      .cycles (TW'(det_r[shed_pkg::RUNTIME_LSB +: 4]) * TW'(shed_pkg::RUNTIME_STEP_CYC)),
      .busy   (rt_busy),
      .done   ()
   );

   assign drop_req = in_shed && !phase_drop_mode && phase_target_r > fit_now && !drop_busy;

   hold_timer #(.W(TW)) u_drop_timer (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (drop_req),
      .cycles (TW'(det_r[shed_pkg::DROP_IVL_LSB +: 4]) * TW'(shed_pkg::DROP_STEP_CYC)), // R15
      .busy   (drop_busy),
      .done   (drop_done)
   );

   // Shedding state
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         state_r <= shed_pkg::ST_FULL;
      else
      begin
         case (state_r)
            shed_pkg::ST_FULL:
               if (enter_ok && !exit_any) // R25
                  state_r <= shed_pkg::ST_SHED;
            shed_pkg::ST_SHED:
               if (exit_any) // R25
                  state_r <= shed_pkg::ST_FULL;
            default:
               state_r <= shed_pkg::ST_FULL;
         endcase
      end
   end

   // Active phase target
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         phase_target_r <= 4'h0;
      else if (!in_shed || exit_any)
         phase_target_r <= phase_num_cfg;
      else if (phase_drop_mode)
         phase_target_r <= fit_now; // R23
      else if (drop_done && phase_target_r > fit_now)
         phase_target_r <= phase_target_r - 4'h1; // R15 R23
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         target_prev_r <= 4'h0;
      else
         target_prev_r <= phase_target_r;
   end

   assign phase_chg = phase_target_r != target_prev_r;
   assign freq_evt  = (loop_r[shed_pkg::FREQ_TRANS_BIT] && evt.transient) ||
                      (loop_r[shed_pkg::FREQ_PHASE_BIT] && phase_chg) ||
                      (loop_r[shed_pkg::FREQ_VID_BIT] && evt.vid_change); // R17
   assign bal_evt   = (loop_r[shed_pkg::BAL_PERIOD_BIT] && evt.period_met) ||
                      (loop_r[shed_pkg::BAL_PHASE_BIT] && phase_chg) ||
                      (loop_r[shed_pkg::BAL_VID_BIT] && evt.vid_change); // R19

   hold_timer #(.W(TW)) u_freq_hold (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (freq_evt),
      .cycles (TW'(loop_r[shed_pkg::FREQ_HOLD_LSB +: 4]) * TW'(HOLD_STEP_CYC)), // R18
      .busy   (freq_busy),
      .done   ()
   );

   hold_timer #(.W(TW)) u_bal_hold (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (bal_evt),
      .cycles (TW'(loop_r[shed_pkg::BAL_HOLD_LSB +: 4]) * TW'(HOLD_STEP_CYC)), // R20
      .busy   (bal_busy),
      .done   ()
   );

   // Loop run flags
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         freq_loop_run_r    <= 1'b0;
         balance_loop_run_r <= 1'b0;
      end
      else
      begin
         freq_loop_run_r    <= loop_r[shed_pkg::FREQ_EN_BIT] && !freq_busy && !freq_evt; // R16 R17
         balance_loop_run_r <= loop_r[shed_pkg::BAL_EN_BIT] && !bal_busy && !bal_evt; // R19 R20
      end
   end

   // AVS current report
   assign avs_prod = 19'(iout_a) * 19'(out_r[shed_pkg::AVS_GAIN_LSB +: 11]); // R1
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         avs_r <= 16'h0000;
      else if (iout_strobe)
         avs_r <= avs_res_sel ? 16'(avs_prod >> shed_pkg::AVS_SHIFT_COARSE) :
                                16'(avs_prod >> shed_pkg::AVS_SHIFT_FINE); // R24
   end

   // Output loop decode and frequency limit
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         vout_cfg_r       <= '0;
         freq_limit_pct_r <= 8'h00;
      end
      else
      begin
         vout_cfg_r.sense_gain       <= out_r[shed_pkg::SENSE_GAIN_LSB +: 2]; // R22
         vout_cfg_r.amp_input_sel    <= out_r[shed_pkg::AMP_SEL_BIT]; // R22
         vout_cfg_r.vid_step_invalid <= out_r[shed_pkg::VID_STEP_LSB + 1]; // R21
         if (out_r[shed_pkg::VID_STEP_LSB +: 2] == 2'b01)
            vout_cfg_r.vid_step <= shed_pkg::VID_STEP_5P0; // R21
         else if (out_r[shed_pkg::VID_STEP_LSB +: 2] != 2'b00)
            vout_cfg_r.vid_step <= 14'h0000;
         else if (out_r[shed_pkg::SENSE_GAIN_LSB +: 2] == 2'b10)
            vout_cfg_r.vid_step <= shed_pkg::VID_STEP_1P95; // R21
         else if (out_r[shed_pkg::SENSE_GAIN_LSB +: 2] == 2'b11)
            vout_cfg_r.vid_step <= shed_pkg::VID_STEP_3P91;
         else
            vout_cfg_r.vid_step <= shed_pkg::VID_STEP_6P25;
         freq_limit_pct_r <= shed_pkg::FREQ_LIM_BASE +
                             8'(tim_r[shed_pkg::FREQ_COEF_LSB +: 3]) * shed_pkg::FREQ_LIM_STEP; // R9
      end
   end

   assign cmd_rdata          = cmd_rdata_r;
   assign cmd_rvalid         = cmd_rvalid_r;
   assign cmd_nack           = cmd_nack_r;
   assign shed_active        = in_shed;
   assign phase_target       = phase_target_r;
   assign freq_limit_pct     = freq_limit_pct_r;
   assign freq_loop_run      = freq_loop_run_r;
   assign balance_loop_run   = balance_loop_run_r;
   assign avs_current_report = avs_r;
   assign vout_cfg           = vout_cfg_r;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_ocp_fire;
      in_shed && ocp_done && tim_r[shed_pkg::OCP_FULL_BIT];
   endsequence

   sequence s_ocp_start;
      !ocp_busy && evt.per_phase_overcurrent && tim_r[shed_pkg::OCP_DELAY_LSB +: 4] == 4'h1;
   endsequence

   a_exit_priority: assert property (in_shed && exit_any |=> !in_shed) // R25
      else $error("exit did not win over entry");
   a_ocp_exit: assert property (s_ocp_fire |=> !in_shed) // R5
      else $error("overcurrent did not force full phase");
   a_ocp_delay: assert property (s_ocp_start |-> ##5 ocp_done) // R4
      else $error("overcurrent delay length wrong");
   a_uv_exit: assert property (in_shed && exit_uv |=> // R7
      !shed_active && phase_target == $past(phase_num_cfg))
      else $error("undervoltage did not restore full phase");
   a_runtime_block: assert property (!in_shed && rt_busy |=> !in_shed) // R14
      else $error("entered shedding during full phase runtime");
   a_drop_one_step: assert property ( // R15
      in_shed && !phase_drop_mode && !exit_any && phase_target_r > 4'h0 ##1
      in_shed && phase_target_r < $past(phase_target_r) |->
      phase_target_r == $past(phase_target_r) - 4'h1)
      else $error("dropped more than one phase");
   a_freq_hold: assert property (freq_evt |=> !freq_loop_run ##1 !freq_loop_run) // R17
      else $error("frequency loop ran during hold");
   a_freq_enable: assert property (!loop_r[shed_pkg::FREQ_EN_BIT] |=> !freq_loop_run) // R16
      else $error("frequency loop ran while disabled");
   a_bal_hold: assert property (bal_evt |=> !balance_loop_run ##1 !balance_loop_run) // R19
      else $error("balance loop ran during hold");
   a_avs_scale: assert property (iout_strobe && !avs_res_sel |=> // R1
      avs_current_report == 16'($past(avs_prod) >> 4))
      else $error("AVS current scaling wrong");
endmodule : rail2_phase_shed_loop_ctrl

//--- hw/shed_pkg.sv
// Constants, field layout and carrier types for the rail 2 shedding control
package shed_pkg;
   // Page-1 command codes
   localparam logic [7:0]  OFS_SHED_THRESHOLD   = 8'hae;
   localparam logic [7:0]  OFS_SHED_TIMING_EXIT = 8'haf;
   localparam logic [7:0]  OFS_SHED_EXIT_DETECT = 8'hb0;
   localparam logic [7:0]  OFS_FREQ_BALANCE     = 8'hb1;
   localparam logic [7:0]  OFS_OUTPUT_LOOP      = 8'hb2;
   localparam logic [15:0] RST_REG              = 16'h0000;
   localparam logic [15:0] OUTPUT_LOOP_WMASK    = 16'hcfff;
   // Threshold register fields
   localparam int HYST_INC_LSB     = 14;
   localparam int HYST_BASE_LSB    = 10;
   localparam int LEVEL_INC_LSB    = 4;
   localparam int LEVEL_BASE_LSB   = 0;
   // Timing and exit register fields
   localparam int OCP_DELAY_LSB    = 12;
   localparam int OCP_FULL_BIT     = 11;
   localparam int OCP_SINGLE_BIT   = 10;
   localparam int UV_EXIT_BIT      = 9;
   localparam int FREQ_RISE_BIT    = 8;
   localparam int FREQ_COEF_LSB    = 5;
   localparam int ENTRY_DELAY_LSB  = 0;
   // Exit detect register fields
   localparam int OFFTIME_EN_BIT   = 15;
   localparam int INTERVAL_EN_BIT  = 14;
   localparam int OFFTIME_CNT_LSB  = 11;
   localparam int RUNTIME_LSB      = 7;
   localparam int INTERVAL_CNT_LSB = 4;
   localparam int DROP_IVL_LSB     = 0;
   // Frequency and balance loop fields
   localparam int FREQ_EN_BIT      = 15;
   localparam int FREQ_TRANS_BIT   = 14;
   localparam int FREQ_PHASE_BIT   = 13;
   localparam int FREQ_VID_BIT     = 12;
   localparam int FREQ_HOLD_LSB    = 8;
   localparam int BAL_EN_BIT       = 7;
   localparam int BAL_PERIOD_BIT   = 6;
   localparam int BAL_PHASE_BIT    = 5;
   localparam int BAL_VID_BIT      = 4;
   localparam int BAL_HOLD_LSB     = 0;
   // Output loop fields
   localparam int VID_STEP_LSB     = 14;
   localparam int SENSE_GAIN_LSB   = 10;
   localparam int AMP_SEL_BIT      = 9;
   localparam int AVS_GAIN_LSB     = 0;
   // Timing
   localparam int CLK_NS           = 20;
   localparam int OCP_STEP_NS      = 100;
   localparam int DROP_STEP_NS     = 2500;
   localparam int RUNTIME_STEP_NS  = 20000;
   localparam int HOLD_STEP_NS     = 100000;
   localparam int OCP_STEP_CYC     = (OCP_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DROP_STEP_CYC    = (DROP_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RUNTIME_STEP_CYC = (RUNTIME_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_STEP_CYC    = (HOLD_STEP_NS + CLK_NS - 1) / CLK_NS;
   // VID step in units of 1/1024 mV
   localparam logic [13:0] VID_STEP_6P25  = 14'h1900;
   localparam logic [13:0] VID_STEP_5P0   = 14'h1400;
   localparam logic [13:0] VID_STEP_1P95  = 14'h07d0;
   localparam logic [13:0] VID_STEP_3P91  = 14'h0fa0;
   localparam logic [7:0]  FREQ_LIM_BASE  = 8'h28;
   localparam logic [7:0]  FREQ_LIM_STEP  = 8'h14;
   localparam int          AVS_SHIFT_FINE   = 4;
   localparam int          AVS_SHIFT_COARSE = 5;

   typedef enum logic [1:0] {ST_FULL = 2'b01, ST_SHED = 2'b10} shed_state_e;

   typedef struct packed {
      logic per_phase_overcurrent;
      logic uv_low;
      logic freq_rise;
      logic pwm1_cycle;
      logic offtime_met;
      logic pwm_np_cycle;
      logic interval_met;
      logic transient;
      logic period_met;
      logic vid_change;
      logic single_phase;
   } shed_evt_s;

   typedef struct packed {
      logic [13:0] vid_step;
      logic        vid_step_invalid;
      logic [1:0]  sense_gain;
      logic        amp_input_sel;
   } vout_cfg_s;
endpackage : shed_pkg

//--- hw/hold_timer.sv
// Reloadable down-counter that marks a held interval and its end
`timescale 1ns/1ps
module hold_timer #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         start,
   input  wire logic [W-1:0] cycles,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] count_r;

   // Start reloads, so a new event extends the hold
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         count_r <= '0;
      else if (start)
         count_r <= cycles;
      else if (count_r != '0)
         count_r <= count_r - W'(1);
   end

   assign busy = (count_r != '0);
   assign done = (!start && count_r == W'(1)) || (start && cycles == '0);
endmodule : hold_timer

//--- sim/cmd_host.sv
// Command host model for the rail 2 register bus
`timescale 1ns/1ps
module cmd_host (
   input  wire logic   clk,
   output logic        cmd_wr,
   output logic        cmd_rd,
   output logic [7:0]  cmd_code,
   output logic [15:0] cmd_wdata
);
   initial
   begin
      cmd_wr    = 1'b0;
      cmd_rd    = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_wr    <= 1'b1;
      cmd_code  <= c;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_wr    <= 1'b0;
      cmd_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] c);
      @(posedge clk);
      cmd_rd   <= 1'b1;
      cmd_code <= c;
      @(posedge clk);
      cmd_rd   <= 1'b0;
   endtask : rd
endmodule : cmd_host

//--- sim/test_rail2_phase_shed_loop_ctrl.sv
// Self-checking bench for rail 2 shedding and loop control
`timescale 1ns/1ps
module test_rail2_phase_shed_loop_ctrl;
   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                cmd_wr;
   logic                cmd_rd;
   logic [7:0]          cmd_code;
   logic [15:0]         cmd_wdata;
   logic [15:0]         cmd_rdata;
   logic                cmd_rvalid;
   logic                cmd_nack;
   logic                avs_res_sel = 1'b0;
   logic                phase_drop_mode = 1'b1;
   logic [7:0]          iout_a = 8'h00;
   logic                iout_strobe = 1'b0;
   shed_pkg::shed_evt_s evt = '0;
   logic                shed_active;
   logic [3:0]          phase_target;
   logic [7:0]          freq_limit_pct;
   logic                freq_loop_run;
   logic                balance_loop_run;
   logic [15:0]         avs_current_report;
   shed_pkg::vout_cfg_s vout_cfg;
   int                  mismatches = 0;
   int                  n_compared = 0;
   logic [13:0]         st [4] = '{shed_pkg::VID_STEP_6P25, shed_pkg::VID_STEP_6P25,
                                   shed_pkg::VID_STEP_1P95, shed_pkg::VID_STEP_3P91};

   cmd_host u_cmd_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
                        .cmd_wdata(cmd_wdata));
   rail2_phase_shed_loop_ctrl #(.HOLD_STEP_CYC(20)) u_rail2_phase_shed_loop_ctrl (
      .clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .cmd_nack(cmd_nack), .phase_num_cfg(4'h4), .phase_drop_mode(phase_drop_mode),
      .avs_res_sel(avs_res_sel), .iout_a(iout_a), .iout_strobe(iout_strobe), .evt(evt),
      .shed_active(shed_active), .phase_target(phase_target),
      .freq_limit_pct(freq_limit_pct), .freq_loop_run(freq_loop_run),
      .balance_loop_run(balance_loop_run), .avs_current_report(avs_current_report),
      .vout_cfg(vout_cfg));

   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] e, input logic nk);
      u_cmd_host.rd(c);
      @(negedge clk);
      chk({cmd_nack, nk ? 1'b0 : cmd_rvalid, cmd_rdata}, {nk, ~nk, e});
   endtask : rd_chk
   task automatic wr_wait(input logic [7:0] c, input logic [15:0] d);
      u_cmd_host.wr(c, d);
      settle(2);
   endtask : wr_wait
   task automatic strobe(input logic [7:0] a);
      @(posedge clk);
      iout_a      <= a;
      iout_strobe <= 1'b1;
      @(posedge clk);
      iout_strobe <= 1'b0;
   endtask : strobe
   task automatic pulse(input shed_pkg::shed_evt_s m);
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= '0;
      settle(3);
   endtask : pulse
   task automatic test_regs;
      for (int i = 0; i < 5; i++)
      begin
         rd_chk(8'hae + 8'(i), shed_pkg::RST_REG, 1'b0);
         u_cmd_host.wr(8'hae + 8'(i), 16'hffff);
         rd_chk(8'hae + 8'(i), (i == 4) ? shed_pkg::OUTPUT_LOOP_WMASK : 16'hffff, 1'b0);
      end
      rd_chk(8'had, 16'h0000, 1'b1);
      $display("test_regs done");
   endtask : test_regs
   task automatic test_vout;
      for (int g = 0; g < 4; g++)
      begin
         wr_wait(shed_pkg::OFS_OUTPUT_LOOP, {4'h0, 2'(g), 10'h200});
         chk(vout_cfg, {st[g], 1'b0, 2'(g), 1'b1});
      end
      wr_wait(shed_pkg::OFS_OUTPUT_LOOP, 16'h4000);
      chk(vout_cfg, {shed_pkg::VID_STEP_5P0, 4'h0});
      wr_wait(shed_pkg::OFS_OUTPUT_LOOP, 16'h8000);
      chk(vout_cfg, {14'h0000, 4'h8});
      for (int c = 0; c < 8; c++)
      begin
         wr_wait(shed_pkg::OFS_SHED_TIMING_EXIT, {8'h00, 3'(c), 5'h00});
         chk(freq_limit_pct, 8'h28 + 8'(c) * 8'h14);
      end
      $display("test_vout done");
   endtask : test_vout
   task automatic test_loops;
      wr_wait(shed_pkg::OFS_FREQ_BALANCE, 16'h9192);
      settle(2);
      chk({freq_loop_run, balance_loop_run}, 2'b11);
      pulse(11'h008);
      chk({freq_loop_run, balance_loop_run}, 2'b11);
      pulse(11'h002);
      chk({freq_loop_run, balance_loop_run}, 2'b00);
      settle(25);
      chk({freq_loop_run, balance_loop_run}, 2'b10);
      settle(20);
      chk({freq_loop_run, balance_loop_run}, 2'b11);
      $display("test_loops done");
   endtask : test_loops
   task automatic test_shed;
      u_cmd_host.wr(shed_pkg::OFS_SHED_EXIT_DETECT, 16'h0000);
      u_cmd_host.wr(shed_pkg::OFS_SHED_THRESHOLD, 16'h3c12);
      wr_wait(shed_pkg::OFS_SHED_TIMING_EXIT, 16'h1a03);
      repeat (2) strobe(8'h03);
      settle(3);
      chk(shed_active, 1'b0);
      strobe(8'h03);
      settle(3);
      chk({shed_active, phase_target}, {1'b1, 4'h2});
      pulse(11'h100);
      chk(shed_active, 1'b1);
      pulse(11'h400);
      chk(shed_active, 1'b1);
      settle(2);
      chk({shed_active, phase_target}, {1'b0, 4'h4});
      repeat (3) strobe(8'h03);
      settle(3);
      pulse(11'h200);
      chk({shed_active, phase_target}, {1'b0, 4'h4});
      u_cmd_host.wr(shed_pkg::OFS_SHED_EXIT_DETECT, 16'h0001);
      phase_drop_mode <= 1'b0;
      repeat (3) strobe(8'h03);
      settle(3);
      chk({shed_active, phase_target}, {1'b1, 4'h4});
      settle(124);
      chk(phase_target, 4'h3);
      settle(126);
      chk(phase_target, 4'h2);
      $display("test_shed done");
   endtask : test_shed
   task automatic test_avs;
      wr_wait(shed_pkg::OFS_OUTPUT_LOOP, 16'h07ff);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         avs_res_sel <= 1'(s);
         strobe(8'hc8);
         settle(2);
         chk(avs_current_report, 16'((32'd200 * 32'h7ff) >> (4 + s)));
      end
      $display("test_avs done");
   endtask : test_avs
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      #1000000;
      mismatches++;
      complete_run;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      test_regs;
      test_vout;
      test_loops;
      test_shed;
      test_avs;
      complete_run;
   end
endmodule : test_rail2_phase_shed_loop_ctrl
